// ---- logic/tcm_regs.vh ----
/*
 * register offsets, field positions, reset values and mode codes of the
 * 8-bit compare/output timer. assumes a 32-bit apb slave, one word a register.
 */
`ifndef TCM_REGS_VH
`define TCM_REGS_VH

// ==========================================
// register byte offsets
`define TCM_CTRL_OFF 12'h000
`define TCM_CNT_OFF 12'h004
`define TCM_CMP_OFF 12'h008
`define TCM_FLAG_OFF 12'h00c
`define TCM_FORCE_OFF 12'h010
`define TCM_PORT_OFF 12'h014

// ==========================================
// control register fields
`define TCM_CTRL_WGM_LSB 0
`define TCM_CTRL_COM_LSB 2
`define TCM_CTRL_EN_BIT 4
`define TCM_CTRL_PRE_LSB 8
`define TCM_CTRL_RST 32'h0000_0000

// ==========================================
// flag register fields
`define TCM_FLAG_OVF_BIT 0
`define TCM_FLAG_CMP_BIT 1

// ==========================================
// port register fields: output value, direction
`define TCM_PORT_VAL_BIT 0
`define TCM_PORT_DIR_BIT 1

// ==========================================
// waveform and compare output modes
`define TCM_WGM_NORMAL 2'h0
`define TCM_WGM_PCPWM 2'h1
`define TCM_WGM_CLRMATCH 2'h2
`define TCM_WGM_FPWM 2'h3
`define TCM_COM_NONE 2'h0
`define TCM_COM_TOGGLE 2'h1
`define TCM_COM_CLEAR 2'h2
`define TCM_COM_SET 2'h3

// ==========================================
// counter limits
`define TCM_MAX 8'hff
`define TCM_BOTTOM 8'h00

`endif

// ---- logic/tcm_sync.v ----
/*
 * two-flop synchroniser for one level.
 * assumes the input is asynchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module tcm_sync (
	// clock and reset
	input wire pclk,
	input wire presetn,
	input wire ce,
	// level
	input wire d,
	output reg q
);

reg meta_ff;

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		meta_ff <= 1'b0;
		q <= 1'b0;
	end else if (ce) begin
		meta_ff <= d;
		q <= meta_ff;
	end
end

endmodule
`default_nettype wire

// ---- logic/tcm_prescaler.v ----
/*
 * prescaler: a one-cycle timer tick from pclk divided by 1..1024.
 * assumes the select code is stable or that a restart on change is fine.
 */
`timescale 1ns/1ps
`default_nettype none

module tcm_prescaler (
	// clock and reset
	input wire pclk,
	input wire presetn,
	input wire ce,
	// selection: 0 stop, 1..7 = /1,/8,/32,/64,/128,/256,/1024
	input wire [2:0] sel,
	output reg tick
);

reg [9:0] div_ff;
reg [9:0] lim;

always @* begin
	case (sel)
	3'h1: lim = 10'h000;
	3'h2: lim = 10'h007;
	3'h3: lim = 10'h01f;
	3'h4: lim = 10'h03f;
	3'h5: lim = 10'h07f;
	3'h6: lim = 10'h0ff;
	3'h7: lim = 10'h3ff;
	default: lim = 10'h000;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		div_ff <= 10'h000;
		tick <= 1'b0;
	end else if (ce) begin
		if (sel == 3'h0) begin
			div_ff <= 10'h000;
			tick <= 1'b0;
		end else if (div_ff >= lim) begin
			div_ff <= 10'h000;
			tick <= 1'b1;
		end else begin
			div_ff <= div_ff + 10'h001;
			tick <= 1'b0;
		end
	end
end

endmodule
`default_nettype wire

// ---- logic/tcm_timer.v ----
/*
 * 8-bit timer/counter with one compare unit and its output pin override,
 * normal, clear-on-match, phase-correct pwm and fast pwm modes, apb register access.
 * assumes an apb master on pclk and an asynchronous pin input.
 */
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tcm_regs.vh"

module tcm_timer (
	// clock and reset
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// interrupt acknowledges from the cpu core
	input wire ovf_ack,
	input wire cmp_ack,
	// flags toward the interrupt controller
	output reg overflow_flag,
	output reg compare_match_flag,
	// pin
	input wire pin_in,
	output reg pin_out,
	output reg pin_oe,
	output reg pin_in_sync,
	// state seen by the rest of the chip
	output reg compare_output_state,
	output reg [7:0] counter_value
);

// ==========================================
// decoding helpers
// modes zero and two are the non-PWM modes
function is_pwm;
	input [1:0] wgm;
	begin
		is_pwm = (wgm == `TCM_WGM_PCPWM) || (wgm == `TCM_WGM_FPWM);
	end
endfunction

// next compare output state for a non-PWM match or force
function next_oc;
	input [1:0] com;
	input cur;
	begin
		case (com)
		`TCM_COM_TOGGLE: next_oc = ~cur;
		`TCM_COM_CLEAR: next_oc = 1'b0;
		`TCM_COM_SET: next_oc = 1'b1;
		default: next_oc = cur;
		endcase
	end
endfunction

// ==========================================
// registers
reg [1:0] waveform_mode_ff;
reg [1:0] compare_output_mode_ff;
reg [2:0] clk_sel_ff;
reg [7:0] compare_value_ff;
reg [7:0] compare_buf_ff;
reg port_val_ff;
reg output_pin_direction_bit_ff;
reg cnt_wr_block_ff;
reg match_pend_ff;
reg dir_down_ff;

wire tick;
wire pin_sync;
wire wr_acc = psel && penable && pwrite;
wire cnt_wr = wr_acc && (paddr == `TCM_CNT_OFF);
wire cmp_wr = wr_acc && (paddr == `TCM_CMP_OFF);
wire ctrl_wr = wr_acc && (paddr == `TCM_CTRL_OFF);
wire flag_wr = wr_acc && (paddr == `TCM_FLAG_OFF);
wire force_wr = wr_acc && (paddr == `TCM_FORCE_OFF) && pwdata[0];
wire port_wr = wr_acc && (paddr == `TCM_PORT_OFF);

function mapped;
	input [11:0] a;
	begin
		mapped = (a == `TCM_CTRL_OFF) || (a == `TCM_CNT_OFF) || (a == `TCM_CMP_OFF) ||
			(a == `TCM_FLAG_OFF) || (a == `TCM_FORCE_OFF) || (a == `TCM_PORT_OFF);
	end
endfunction

// ==========================================
// submodules
tcm_prescaler i_tcm_prescaler (
	.pclk(pclk),
	.presetn(presetn),
	.ce(clk_en),
	.sel(clk_sel_ff),
	.tick(tick)
);

tcm_sync i_tcm_sync (
	.pclk(pclk),
	.presetn(presetn),
	.ce(clk_en),
	.d(pin_in),
	.q(pin_sync)
);

// ==========================================
// counter and compare
wire pwm = is_pwm(waveform_mode_ff);
// a counter write hides one match, so compare may be set equal to the count
wire match = (counter_value == compare_value_ff) && !cnt_wr_block_ff;
reg [7:0] nxt_counter;
reg nxt_dir_down;
reg nxt_ovf_set;

// counting depends on waveform mode, and in clear-on-match mode also on the compare match
always @* begin
	nxt_counter = counter_value;
	nxt_dir_down = dir_down_ff;
	nxt_ovf_set = 1'b0;
	case (waveform_mode_ff)
	// a compare below the count is missed until the count wraps
	`TCM_WGM_CLRMATCH: begin
		if (match) begin
			nxt_counter = `TCM_BOTTOM;
		end else begin
			nxt_counter = counter_value + 8'h01;
			nxt_ovf_set = (counter_value == `TCM_MAX);
		end
	end
	`TCM_WGM_PCPWM: begin
		if (dir_down_ff) begin
			nxt_counter = counter_value - 8'h01;
			if (counter_value == 8'h01)
				nxt_dir_down = 1'b0;
			nxt_ovf_set = (counter_value == 8'h01);
		end else begin
			nxt_counter = counter_value + 8'h01;
			if (counter_value == 8'hfe)
				nxt_dir_down = 1'b1;
		end
	end
	`TCM_WGM_FPWM: begin
		nxt_counter = counter_value + 8'h01;
		nxt_ovf_set = (counter_value == `TCM_MAX);
	end
	default: begin
		nxt_counter = counter_value + 8'h01;
		nxt_ovf_set = (counter_value == `TCM_MAX);
	end
	endcase
end

// compare output state on a timer tick
reg nxt_oc;
always @* begin
	nxt_oc = compare_output_state;
	if (!pwm) begin
		if (match)
			nxt_oc = next_oc(compare_output_mode_ff, compare_output_state);
	end else if (compare_output_mode_ff[1]) begin
		// pwm: set or clear by polarity
		if (match)
			nxt_oc = compare_output_mode_ff[0] ^ (waveform_mode_ff == `TCM_WGM_PCPWM && dir_down_ff);
		else if (waveform_mode_ff == `TCM_WGM_FPWM && counter_value == `TCM_MAX)
			nxt_oc = ~compare_output_mode_ff[0];
	end else if (compare_output_mode_ff == `TCM_COM_TOGGLE && match) begin
		nxt_oc = ~compare_output_state;
	end
end

// counter: a cpu write wins over counting
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		counter_value <= 8'h00;
		dir_down_ff <= 1'b0;
		cnt_wr_block_ff <= 1'b0;
	end else if (clk_en) begin
		// the write blocks the match of the next tick, even when stopped
		if (cnt_wr) begin
			counter_value <= pwdata[7:0];
			cnt_wr_block_ff <= 1'b1;
		end else if (tick) begin
			counter_value <= nxt_counter;
			dir_down_ff <= nxt_dir_down;
			cnt_wr_block_ff <= 1'b0;
		end
	end
end

// ==========================================
// compare value: direct in non-PWM, at the bottom in PWM
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		compare_value_ff <= 8'h00;
		compare_buf_ff <= 8'h00;
	end else if (clk_en) begin
		if (cmp_wr)
			compare_buf_ff <= pwdata[7:0];
		if (cmp_wr && !pwm)
			compare_value_ff <= pwdata[7:0];
		else if (pwm && tick && !cnt_wr && nxt_counter == `TCM_BOTTOM)
			compare_value_ff <= compare_buf_ff;
	end
end

// ==========================================
// compare output state: force has priority over the mode's own action in non-PWM modes and is ignored in PWM modes
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		compare_output_state <= 1'b0;
	end else if (clk_en) begin
		if (force_wr && !pwm)
			compare_output_state <= next_oc(compare_output_mode_ff, compare_output_state);
		else if (tick && !cnt_wr)
			compare_output_state <= nxt_oc;
	end
end

// ==========================================
// sticky flags: the timer sets, software or the acknowledge clears; set wins
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		match_pend_ff <= 1'b0;
		overflow_flag <= 1'b0;
		compare_match_flag <= 1'b0;
	end else if (clk_en) begin
		// match flag raised one timer cycle later
		if (tick)
			match_pend_ff <= match && !cnt_wr;
		if (tick && match_pend_ff)
			compare_match_flag <= 1'b1;
		else if (cmp_ack || (flag_wr && pwdata[`TCM_FLAG_CMP_BIT]))
			compare_match_flag <= 1'b0;
		if (tick && !cnt_wr && nxt_ovf_set)
			overflow_flag <= 1'b1;
		else if (ovf_ack || (flag_wr && pwdata[`TCM_FLAG_OVF_BIT]))
			overflow_flag <= 1'b0;
	end
end

// ==========================================
// control and port registers
// a mode field change takes effect at once, with no wait for a match
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		waveform_mode_ff <= `TCM_WGM_NORMAL;
		compare_output_mode_ff <= `TCM_COM_NONE;
		clk_sel_ff <= 3'h0;
		port_val_ff <= 1'b0;
		output_pin_direction_bit_ff <= 1'b0;
	end else if (clk_en) begin
		if (ctrl_wr) begin
			waveform_mode_ff <= pwdata[`TCM_CTRL_WGM_LSB +: 2];
			compare_output_mode_ff <= pwdata[`TCM_CTRL_COM_LSB +: 2];
			clk_sel_ff <= pwdata[`TCM_CTRL_PRE_LSB +: 3];
		end
		if (port_wr) begin
			port_val_ff <= pwdata[`TCM_PORT_VAL_BIT];
			output_pin_direction_bit_ff <= pwdata[`TCM_PORT_DIR_BIT];
		end
	end
end

// ==========================================
// pin mux
// both pin outputs lag their sources by one cycle
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pin_out <= 1'b0;
		pin_oe <= 1'b0;
		pin_in_sync <= 1'b0;
	end else if (clk_en) begin
		// mode field alone selects the source
		if (compare_output_mode_ff != `TCM_COM_NONE)
			pin_out <= compare_output_state;
		else
			pin_out <= port_val_ff;
		pin_oe <= output_pin_direction_bit_ff;
		pin_in_sync <= pin_sync;
	end
end

// ==========================================
// apb read and answer, zero wait state
// unmapped words answer with an error, read zero and ignore writes
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		prdata <= 32'h0000_0000;
		pready <= 1'b0;
		pslverr <= 1'b0;
	end else if (clk_en) begin
		pready <= psel && !penable;
		pslverr <= psel && !penable && !mapped(paddr);
		prdata <= 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			case (paddr)
			`TCM_CTRL_OFF: prdata <= {21'h0, clk_sel_ff, 4'h0,
				compare_output_mode_ff, waveform_mode_ff};
			`TCM_CNT_OFF: prdata <= {24'h0, counter_value};
			`TCM_CMP_OFF: prdata <= {24'h0, (pwm ? compare_buf_ff : compare_value_ff)};
			`TCM_FLAG_OFF: prdata <= {30'h0, compare_match_flag, overflow_flag};
			`TCM_PORT_OFF: prdata <= {29'h0, pin_sync, output_pin_direction_bit_ff,
				port_val_ff};
			default: prdata <= 32'h0000_0000;
			endcase
		end
	end
end

endmodule
`default_nettype wire

// ---- test/tcm_timer_checker.sv ----
/* checker: apb answer timing and flag behaviour of the compare timer.
   assumes it is bound to tcm_timer and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none

module tcm_timer_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// flags and counter
	input wire logic ovf_ack,
	input wire logic cmp_ack,
	input wire logic overflow_flag,
	input wire logic compare_match_flag,
	input wire logic [7:0] counter_value
);
	// ==========================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire flag_wr = psel && penable && pwrite && paddr == 12'h00c;

	a_ready_next: assert property (psel && !penable && clk_en |=> pready)
		else $error("no answer after setup");
	a_ready_pulse: assert property (pready && clk_en |=> !pready)
		else $error("ready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_unmapped: assert property (psel && !penable && clk_en && paddr > 12'h014 |=> pslverr)
		else $error("unmapped access not refused");
	a_ovf_at_zero: assert property ($rose(overflow_flag) |-> counter_value == 8'h00)
		else $error("overflow flag rose off zero");
	a_ovf_sticky: assert property (overflow_flag && !ovf_ack &&
		!(flag_wr && pwdata[0]) |=> overflow_flag)
		else $error("overflow flag dropped alone");
	a_cmp_sticky: assert property (compare_match_flag && !cmp_ack &&
		!(flag_wr && pwdata[1]) |=> compare_match_flag)
		else $error("compare flag dropped alone");
	a_ovf_ack_clear: assert property (ovf_ack && clk_en &&
		counter_value != 8'hff |=> !overflow_flag)
		else $error("overflow ack ignored");
	c_ovf: cover property ($rose(overflow_flag));
	c_wrap: cover property (counter_value == 8'hff ##1 counter_value == 8'h00);
	c_cmp: cover property ($rose(compare_match_flag));
	c_err: cover property (pslverr);
endmodule

bind tcm_timer tcm_timer_checker i_tcm_timer_checker (.pclk(pclk), .presetn(presetn),
	.clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .ovf_ack(ovf_ack),
	.cmp_ack(cmp_ack), .overflow_flag(overflow_flag),
	.compare_match_flag(compare_match_flag), .counter_value(counter_value));

`default_nettype wire

// ---- test/tcm_timer_tb_top.sv ----
/* testbench: drives tcm_timer over apb and its side inputs, checks outputs.
   assumes tcm_regs.vh on the include path and the checker bound beside it. */
`timescale 1ns/1ps
`default_nettype none
`include "tcm_regs.vh"

module tcm_timer_tb_top;
	logic pclk, presetn, clk_en, psel, penable, pwrite, ovf_ack, cmp_ack, pin_in, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	logic [7:0] top;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, overflow_flag, compare_match_flag;
	wire logic pin_out, pin_oe, pin_in_sync, compare_output_state;
	wire logic [7:0] counter_value;
	int failures, check_count, i;
	logic [1:0] cseq [7] = '{`TCM_COM_SET, `TCM_COM_CLEAR, `TCM_COM_TOGGLE,
		`TCM_COM_TOGGLE, `TCM_COM_NONE, `TCM_COM_SET, `TCM_COM_NONE};
	logic [6:0] eseq = 7'b1100101;

	tcm_timer i_tcm_timer (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ovf_ack(ovf_ack),
		.cmp_ack(cmp_ack), .overflow_flag(overflow_flag),
		.compare_match_flag(compare_match_flag), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in_sync(pin_in_sync),
		.compare_output_state(compare_output_state), .counter_value(counter_value));

	// ==========================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			print_verdict;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_cnt(input logic [7:0] v);
		int n;
		n = 0;
		while (counter_value !== v && n < 600) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 600) begin
			failures++;
			print_verdict;
		end
	endtask

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ==========================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, ovf_ack, cmp_ack, pin_in} = 7'h0;
		clk_en = 1'b1;
		paddr = 12'h0;
		pwdata = 32'h0;
		failures = 0;
		check_count = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `TCM_CTRL_OFF, 32'h0);
		chk(rd, `TCM_CTRL_RST);
		apb(1, 12'h020, 32'h1);
		chk(err, 1'b1);
		apb(0, 12'h020, 32'h0);
		chk(rd, 32'h0);
		// forced actions with the clock stopped and the pin still an input
		apb(1, `TCM_CNT_OFF, 32'h33);
		for (i = 0; i < 7; i++) begin
			apb(1, `TCM_CTRL_OFF, {28'h0, cseq[i], i[0] ? `TCM_WGM_CLRMATCH : `TCM_WGM_NORMAL});
			apb(1, `TCM_FORCE_OFF, 32'h1);
			@(posedge pclk);
			chk(compare_output_state, eseq[i]);
			chk(pin_oe, 1'b0);
		end
		chk({compare_match_flag, counter_value}, 9'h033);
		apb(1, `TCM_PORT_OFF, 32'h2);
		repeat (2) @(posedge pclk);
		chk({pin_oe, pin_out}, 2'b10);
		apb(1, `TCM_CTRL_OFF, {28'h0, `TCM_COM_TOGGLE, `TCM_WGM_FPWM});
		repeat (2) @(posedge pclk);
		chk({pin_oe, pin_out}, 2'b11);
		apb(1, `TCM_FORCE_OFF, 32'h1);
		@(posedge pclk);
		chk(compare_output_state, 1'b1);
		pin_in <= 1'b1;
		repeat (5) @(posedge pclk);
		chk(pin_in_sync, 1'b1);
		apb(0, `TCM_PORT_OFF, 32'h0);
		chk(rd, 32'h6);
		// normal mode wrap and overflow flag
		apb(1, `TCM_CNT_OFF, 32'hfd);
		apb(1, `TCM_CTRL_OFF, 32'h100);
		chk(overflow_flag, 1'b0);
		apb(0, `TCM_CTRL_OFF, 32'h0);
		chk(rd, 32'h100);
		wait_cnt(8'h00);
		chk(overflow_flag, 1'b1);
		ovf_ack <= 1'b1;
		@(posedge pclk);
		ovf_ack <= 1'b0;
		@(posedge pclk);
		chk(overflow_flag, 1'b0);
		wait_cnt(8'h80);
		// clock enable low freezes the count
		clk_en <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(counter_value, 8'h81);
		chk(compare_match_flag, 1'b1);
		clk_en <= 1'b1;
		apb(1, `TCM_FLAG_OFF, 32'h3);
		apb(0, `TCM_FLAG_OFF, 32'h0);
		chk(rd, 32'h0);
		// compare below the running count: missed match, full wrap
		apb(1, `TCM_CMP_OFF, 32'h5);
		apb(0, `TCM_CMP_OFF, 32'h0);
		chk(rd, 32'h5);
		apb(1, `TCM_CTRL_OFF, {20'h0, 4'h1, 4'h0, `TCM_COM_TOGGLE, `TCM_WGM_CLRMATCH});
		wait_cnt(8'hff);
		wait_cnt(8'h00);
		chk(overflow_flag, 1'b1);
		top = 8'h0;
		for (i = 0; i < 40; i++) begin
			@(posedge pclk);
			if (counter_value > top)
				top = counter_value;
		end
		chk(top, 8'h5);
		chk(compare_match_flag, 1'b1);
		apb(1, `TCM_CTRL_OFF, 32'h0);
		cmp_ack <= 1'b1;
		@(posedge pclk);
		cmp_ack <= 1'b0;
		@(posedge pclk);
		chk(compare_match_flag, 1'b0);
		print_verdict;
	end
endmodule

`default_nettype wire
